// ==== dv/pmc_sva.sv ====
/* checker: port assertions for the power mode controller.
   assumes one clock domain and a bind onto the design top. */
`timescale 1ns/100ps
`default_nettype none
module pmc_sva
    import pwr_mode_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic [SUBSYS_W-1:0] SUBSYS_CLK_EN,
    input wire logic [SUBSYS_W-1:0] SUBSYS_BIAS_EN,
    input wire logic [SUBSYS_W-1:0] SUBSYS_LEAK_LOW,
    input wire logic CPU_EN,
    input wire logic LOW_SPEED_CLK_ON,
    input wire logic TIMEWHEEL_ON,
    input wire logic RTC_ON,
    input wire logic IO_HOLD,
    input wire logic [1:0] MODE
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);
    // the three gating views of a subsystem never disagree
    gate_pair_a: assert property (SUBSYS_BIAS_EN == SUBSYS_CLK_EN && SUBSYS_LEAK_LOW == ~SUBSYS_CLK_EN)
        else $error("gating views differ");
    cpu_bit_a: assert property (CPU_EN == SUBSYS_CLK_EN[0]) else $error("cpu enable off bit0");
    sleep_gate_a: assert property (MODE == 2'h2 |-> SUBSYS_CLK_EN == 8'h00 && LOW_SPEED_CLK_ON && TIMEWHEEL_ON && RTC_ON)
        else $error("sleep gating wrong");
    hib_stop_a: assert property (MODE == 2'h3 |-> SUBSYS_CLK_EN == 8'h00 && !LOW_SPEED_CLK_ON && !RTC_ON && IO_HOLD)
        else $error("hibernate gating wrong");
    mode_write_a: assert property (WR && ADDR == REG_MODE_REQ |=> MODE == $past(WDATA[1:0]))
        else $error("mode write lost");
    // low power only through the mode request; wakeup lands in active with the cpu on
    mode_cause_a: assert property ($changed(MODE) && !$past(WR && ADDR == REG_MODE_REQ) |-> MODE == 2'h0 && CPU_EN)
        else $error("mode moved without cause");
    act_tmpl_a: assert property (WR && ADDR == REG_TMPL_ACT && MODE == 2'h0 ##1 MODE == 2'h0 |->
        SUBSYS_CLK_EN[7:1] == $past(WDATA[7:1])) else $error("template not applied");
    stat_read_a: assert property (RD && ADDR == REG_MODE_STAT |=> RDATA == {6'h00, $past(MODE)})
        else $error("status read wrong");
    rdata_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00) else $error("read data outside slot");
endmodule
bind power_mode_controller pmc_sva chk (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .SUBSYS_CLK_EN(SUBSYS_CLK_EN), .SUBSYS_BIAS_EN(SUBSYS_BIAS_EN),
    .SUBSYS_LEAK_LOW(SUBSYS_LEAK_LOW), .CPU_EN(CPU_EN), .LOW_SPEED_CLK_ON(LOW_SPEED_CLK_ON),
    .TIMEWHEEL_ON(TIMEWHEEL_ON), .RTC_ON(RTC_ON), .IO_HOLD(IO_HOLD), .MODE(MODE));
`default_nettype wire

// ==== dv/tb_top.sv ====
/* testbench for the power mode controller: register port, modes, wakeup.
   assumes the checker is bound in and wake inputs are plain levels. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import pwr_mode_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic [4:0] wk = 5'h00;
    logic [7:0] rdata, clk_en, bias_en, leak_low;
    logic cpu_en, ls_on, tw_on, rtc_on, io_hold, dig_en, ana_en;
    logic [1:0] mode;
    int error_cnt = 0;
    int compares = 0;
    power_mode_controller dut (.CLK_SYS(clk), .RESET_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .WAKE_PERIPH(wk[0]), .WAKE_SUPERVISOR(wk[1]), .WAKE_TIMEWHEEL(wk[2]), .WAKE_PIN(wk[3]),
        .WAKE_RESET_SRC(wk[4]), .SUBSYS_CLK_EN(clk_en), .SUBSYS_BIAS_EN(bias_en), .SUBSYS_LEAK_LOW(leak_low),
        .CPU_EN(cpu_en), .LOW_SPEED_CLK_ON(ls_on), .TIMEWHEEL_ON(tw_on), .RTC_ON(rtc_on), .IO_HOLD(io_hold),
        .DIG_REG_EN(dig_en), .ANA_REG_EN(ana_en), .MODE(mode));
    // 20 MHz system clock
    always #25 clk = ~clk;
    task automatic end_of_test();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rreg(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    // bounded wait: the synchroniser delay is only roughly known
    task automatic wait_mode(input logic [1:0] exp);
        int n;
        n = 0;
        while (mode !== exp && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (mode !== exp) begin
            error_cnt++;
            $display("BAD t=%0t mode wait ran out", $time);
            end_of_test();
        end
    endtask
    task automatic t_reset();
        rreg(REG_MODE_STAT, 8'h00);
        rreg(REG_TMPL_ACT, TMPL_ACT_RST);
        rreg(REG_TMPL_ALT, TMPL_ALT_RST);
        rreg(REG_WAKE_EN, {3'h0, WAKE_EN_RST});
        rreg(REG_REGULATOR, 8'h03);
        rreg(4'hF, 8'h00);
        chk({6'h00, ana_en, dig_en}, 8'h03);
        wreg(REG_REGULATOR, 8'h00);
        chk({6'h00, ana_en, dig_en}, 8'h00);
    endtask
    task automatic t_template();
        wreg(REG_TMPL_ACT, 8'h5A);
        chk(clk_en, 8'h5A);
        rreg(REG_SUBSYS_ON, 8'h5A);
        wreg(REG_TMPL_ALT, 8'h3C);
        chk(clk_en, 8'h5A);
        wreg(REG_MODE_REQ, 8'h01);
        chk(clk_en, 8'h3C);
        rreg(REG_MODE_STAT, 8'h01);
        wreg(REG_TMPL_ALT, 8'h81);
        chk(leak_low, 8'h7E);
        chk(bias_en, 8'h81);
        wreg(REG_MODE_REQ, 8'h00);
        chk(clk_en, 8'h5A);
    endtask
    // every wake source in turn pulls sleep back to active, cpu forced on
    task automatic t_wake_all();
        for (int i = 0; i < 5; i++) begin
            wreg(REG_MODE_REQ, 8'h02);
            chk({4'h0, ls_on, tw_on, rtc_on, io_hold}, 8'h0E);
            @(posedge clk);
            wk[i] <= 1'b1;
            wait_mode(MODE_ACTIVE);
            chk(clk_en, 8'h5B);
            @(posedge clk);
            wk[i] <= 1'b0;
            repeat (8) @(posedge clk);
        end
    endtask
    task automatic t_masked();
        wreg(REG_WAKE_EN, 8'h1E);
        wreg(REG_TMPL_ACT, 8'h5A);
        wreg(REG_MODE_REQ, 8'h02);
        @(posedge clk);
        wk[0] <= 1'b1;
        repeat (12) @(posedge clk);
        #1;
        chk({6'h00, mode}, 8'h02);
        @(posedge clk);
        wk[0] <= 1'b0;
        wreg(REG_WAKE_EN, 8'h1F);
        wreg(REG_MODE_REQ, 8'h00);
        chk(clk_en, 8'h5A);
    endtask
    task automatic t_hibernate();
        wreg(REG_MODE_REQ, 8'h03);
        chk({4'h0, ls_on, tw_on, rtc_on, io_hold}, 8'h01);
        chk(clk_en, 8'h00);
        // timewheel and reset source rise too; neither may wake from hibernate
        @(posedge clk);
        wk <= 5'h14;
        repeat (12) @(posedge clk);
        #1;
        chk({6'h00, mode}, 8'h03);
        @(posedge clk);
        wk <= 5'h1C;
        wait_mode(MODE_ACTIVE);
        chk(clk_en, 8'h5B);
        chk({7'h00, io_hold}, 8'h00);
        @(posedge clk);
        wk <= 5'h00;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_template();
        t_wake_all();
        t_masked();
        t_hibernate();
        end_of_test();
    end
endmodule
`default_nettype wire

// ==== src/power_mode_controller.sv ====
/*
 * global power mode controller: four modes, per mode enable templates,
 * clock/bias/leakage gating per subsystem, wakeup back to active with
 * processor re-enable, regulator enables and hibernate pin hold.
 * assumes firmware on a plain register port in the CLK_SYS domain and
 * wakeup levels from outside the domain (synchronised here).
 */
// How it works
// - four modes active, alternate active, sleep, hibernate, falling power.
// - in active mode the active template bits decide enabled resources, except the processor bit that a wakeup forces on.
// - disabled resource gets clock gated, bias off and leakage lowered.
// - template writes take effect on subsystems at once, no mode change.
// - separate templates for active and alternate active modes.
// - processor may clear its own enable; next wakeup re-enables it.
// - wakeup forces mode to active and enables processor over template.
// - after reset the mode status reads active.
// - sleep disables everything but low speed clock, timewheel and rtc.
// - hibernate stops all clocks, keeps state, wakes only on pin events.
// - core regulator enables reset to on; firmware may clear them.
// - wakeup sources each enabled: peripherals, supervisor, timewheel, pins, reset.
// - in hibernate output pins hold levels and pin interrupt setup stays.
`timescale 1ns/100ps
`default_nettype none
module power_mode_controller
    import pwr_mode_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic WAKE_PERIPH,
    input wire logic WAKE_SUPERVISOR,
    input wire logic WAKE_TIMEWHEEL,
    input wire logic WAKE_PIN,
    input wire logic WAKE_RESET_SRC,
    output logic [SUBSYS_W-1:0] SUBSYS_CLK_EN,
    output logic [SUBSYS_W-1:0] SUBSYS_BIAS_EN,
    output logic [SUBSYS_W-1:0] SUBSYS_LEAK_LOW,
    output logic CPU_EN,
    output logic LOW_SPEED_CLK_ON,
    output logic TIMEWHEEL_ON,
    output logic RTC_ON,
    output logic IO_HOLD,
    output logic DIG_REG_EN,
    output logic ANA_REG_EN,
    output logic [1:0] MODE
);

    // reset release: asserted at once, released after two edges
    logic rst_s1_r, rst_n_r;
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    // wakeup inputs come from other logic and pins, so synchronise
    logic [WAKE_W-1:0] wake_raw, wake_lvl, wake_prev_r, wake_prev_nxt;
    assign wake_raw = {WAKE_RESET_SRC, WAKE_PIN, WAKE_TIMEWHEEL, WAKE_SUPERVISOR, WAKE_PERIPH};

    wake_sync #(.W(WAKE_W)) u_wake_sync (
        .clk(CLK_SYS),
        .rst_n(rst_n_r),
        .async_in(wake_raw),
        .sync_out(wake_lvl)
    );

    // register state
    pwr_mode_t mode_r, mode_nxt;
    logic [SUBSYS_W-1:0] tmpl_act_r, tmpl_act_nxt;
    logic [SUBSYS_W-1:0] tmpl_alt_r, tmpl_alt_nxt;
    logic [WAKE_W-1:0] wake_en_r, wake_en_nxt;
    logic [1:0] regulator_r, regulator_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic cpu_force_r, cpu_force_nxt;
    subsys_ctl_t ctl_r, ctl_nxt;
    low_power_ctl_t lp_r, lp_nxt;

    // a source may wake the chip only if enabled and allowed in this mode
    function automatic logic [WAKE_W-1:0] wake_allowed(input pwr_mode_t m, input logic [WAKE_W-1:0] en);
        logic [WAKE_W-1:0] mask;
        mask = en;
        if (m == MODE_HIBERNATE) begin
            mask = '0;
            mask[WAKE_PIN_BIT] = en[WAKE_PIN_BIT];
        end
        return mask;
    endfunction

    // rising edges of enabled sources make one wakeup event
    logic [WAKE_W-1:0] wake_rise;
    logic wake_evt;
    assign wake_rise = wake_lvl & ~wake_prev_r;
    assign wake_evt = |(wake_rise & wake_allowed(mode_r, wake_en_r));
    assign wake_prev_nxt = wake_lvl;

    // active template, alternate template, or all off, chosen by the next mode
    function automatic logic [SUBSYS_W-1:0] tmpl_for(input pwr_mode_t m,
            input logic [SUBSYS_W-1:0] act, input logic [SUBSYS_W-1:0] alt);
        case (m)
            MODE_ACTIVE: tmpl_for = act;
            MODE_ALT: tmpl_for = alt;
            default: tmpl_for = '0;
        endcase
    endfunction

    logic wr_hit_mode;
    assign wr_hit_mode = WR && (ADDR == REG_MODE_REQ);

    // mode, templates and control registers
    always_comb begin
        mode_nxt = mode_r;
        tmpl_act_nxt = tmpl_act_r;
        tmpl_alt_nxt = tmpl_alt_r;
        wake_en_nxt = wake_en_r;
        regulator_nxt = regulator_r;
        cpu_force_nxt = cpu_force_r;
        if (WR) begin
            case (ADDR)
                REG_MODE_REQ: begin
                    mode_nxt = pwr_mode_t'(WDATA[1:0]);
                end
                REG_TMPL_ACT: begin
                    tmpl_act_nxt = WDATA[SUBSYS_W-1:0];
                    if (!WDATA[TMPL_CPU_BIT]) begin
                        cpu_force_nxt = 1'b0;
                    end
                end
                REG_TMPL_ALT: begin
                    tmpl_alt_nxt = WDATA[SUBSYS_W-1:0];
                end
                REG_WAKE_EN: begin
                    wake_en_nxt = WDATA[WAKE_W-1:0];
                end
                REG_REGULATOR: begin
                    regulator_nxt = WDATA[1:0];
                end
                default: begin
                end
            endcase
        end
        // a wakeup wins over a same cycle mode request
        if (wake_evt) begin
            mode_nxt = MODE_ACTIVE;
            cpu_force_nxt = 1'b1;
        end else if (wr_hit_mode && pwr_mode_t'(WDATA[1:0]) == MODE_ACTIVE) begin
            cpu_force_nxt = cpu_force_r;
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
        if (!rst_n_r) begin
            mode_r <= MODE_ACTIVE;
            tmpl_act_r <= TMPL_ACT_RST;
            tmpl_alt_r <= TMPL_ALT_RST;
            wake_en_r <= WAKE_EN_RST;
            regulator_r <= REGULATOR_RST;
            cpu_force_r <= 1'b0;
            wake_prev_r <= '0;
        end else begin
            mode_r <= mode_nxt;
            tmpl_act_r <= tmpl_act_nxt;
            tmpl_alt_r <= tmpl_alt_nxt;
            wake_en_r <= wake_en_nxt;
            regulator_r <= regulator_nxt;
            cpu_force_r <= cpu_force_nxt;
            wake_prev_r <= wake_prev_nxt;
        end
    end

    // gating outputs follow registered mode and templates
    logic [SUBSYS_W-1:0] en_vec;
    always_comb begin
        en_vec = tmpl_for(mode_nxt, tmpl_act_nxt, tmpl_alt_nxt);
        if (mode_nxt == MODE_ACTIVE && cpu_force_nxt) begin
            en_vec[TMPL_CPU_BIT] = 1'b1;
        end
        ctl_nxt.clk_en = en_vec;
        ctl_nxt.bias_en = en_vec;
        ctl_nxt.leak_low = ~en_vec;
        lp_nxt.low_speed_clk_on = (mode_nxt != MODE_HIBERNATE);
        lp_nxt.timewheel_on = (mode_nxt != MODE_HIBERNATE);
        lp_nxt.rtc_on = (mode_nxt != MODE_HIBERNATE);
        lp_nxt.io_hold = (mode_nxt == MODE_HIBERNATE);
    end

    always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ctl_r.clk_en <= TMPL_ACT_RST;
            ctl_r.bias_en <= TMPL_ACT_RST;
            ctl_r.leak_low <= ~TMPL_ACT_RST;
            lp_r <= '{low_speed_clk_on: 1'b1, timewheel_on: 1'b1, rtc_on: 1'b1, io_hold: 1'b0};
        end else begin
            ctl_r <= ctl_nxt;
            lp_r <= lp_nxt;
        end
    end

    // read data, valid the cycle after the strobe only
    always_comb begin
        rdata_nxt = DATA_ZERO;
        if (RD) begin
            case (ADDR)
                REG_MODE_REQ, REG_MODE_STAT: rdata_nxt = {6'h00, mode_r};
                REG_TMPL_ACT: rdata_nxt = tmpl_act_r;
                REG_TMPL_ALT: rdata_nxt = tmpl_alt_r;
                REG_WAKE_EN: rdata_nxt = {3'h0, wake_en_r};
                REG_REGULATOR: rdata_nxt = {6'h00, regulator_r};
                REG_SUBSYS_ON: rdata_nxt = ctl_r.clk_en;
                default: rdata_nxt = DATA_ZERO;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rdata_r <= DATA_ZERO;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign RDATA = rdata_r;
    assign SUBSYS_CLK_EN = ctl_r.clk_en;
    assign SUBSYS_BIAS_EN = ctl_r.bias_en;
    assign SUBSYS_LEAK_LOW = ctl_r.leak_low;
    assign CPU_EN = ctl_r.clk_en[TMPL_CPU_BIT];
    assign LOW_SPEED_CLK_ON = lp_r.low_speed_clk_on;
    assign TIMEWHEEL_ON = lp_r.timewheel_on;
    assign RTC_ON = lp_r.rtc_on;
    assign IO_HOLD = lp_r.io_hold;
    assign DIG_REG_EN = regulator_r[REG_DIG_BIT];
    assign ANA_REG_EN = regulator_r[REG_ANA_BIT];
    assign MODE = mode_r;
endmodule
`default_nettype wire

// ==== src/pwr_mode_pkg.sv ====
/*
 * power mode controller package: register offsets, field layouts,
 * reset values, mode encoding and the subsystem enable carrier.
 * assumes a single system clock domain; imported by both design files.
 */
package pwr_mode_pkg;

    // global power modes, in order of falling consumption
    typedef enum logic [1:0] {
        MODE_ACTIVE    = 2'b00,
        MODE_ALT       = 2'b01,
        MODE_SLEEP     = 2'b10,
        MODE_HIBERNATE = 2'b11
    } pwr_mode_t;

    localparam int SUBSYS_W = 8;

    // register word offsets on the plain register port
    localparam logic [3:0] REG_MODE_REQ   = 4'h0;
    localparam logic [3:0] REG_MODE_STAT  = 4'h1;
    localparam logic [3:0] REG_TMPL_ACT   = 4'h2;
    localparam logic [3:0] REG_TMPL_ALT   = 4'h3;
    localparam logic [3:0] REG_WAKE_EN    = 4'h4;
    localparam logic [3:0] REG_REGULATOR  = 4'h5;
    localparam logic [3:0] REG_SUBSYS_ON  = 4'h6;

    // template bit that enables the processor
    localparam int TMPL_CPU_BIT = 0;

    // wake enable field positions
    localparam int WAKE_PERIPH_BIT = 0;
    localparam int WAKE_SUPV_BIT = 1;
    localparam int WAKE_TW_BIT = 2;
    localparam int WAKE_PIN_BIT = 3;
    localparam int WAKE_RESET_BIT = 4;
    localparam int WAKE_W = 5;

    // regulator control field positions
    localparam int REG_DIG_BIT = 0;
    localparam int REG_ANA_BIT = 1;

    // reset values
    localparam logic [SUBSYS_W-1:0] TMPL_ACT_RST = 8'hFF;
    localparam logic [SUBSYS_W-1:0] TMPL_ALT_RST = 8'hFE;
    localparam logic [WAKE_W-1:0] WAKE_EN_RST = 5'h1F;
    localparam logic [1:0] REGULATOR_RST = 2'h3;
    localparam logic [7:0] DATA_ZERO = 8'h00;

    // what each subsystem receives when it is gated
    typedef struct packed {
        logic [SUBSYS_W-1:0] clk_en;
        logic [SUBSYS_W-1:0] bias_en;
        logic [SUBSYS_W-1:0] leak_low;
    } subsys_ctl_t;

    // clocks that keep running in sleep, plus the hibernate pin hold
    typedef struct packed {
        logic low_speed_clk_on;
        logic timewheel_on;
        logic rtc_on;
        logic io_hold;
    } low_power_ctl_t;

endpackage

// ==== src/wake_sync.sv ====
/*
 * three flop synchroniser for a bundle of wakeup levels from pins and
 * other logic. a change counts once the second and third flops agree.
 * assumes the reset is already released synchronously by the caller.
 */
`timescale 1ns/100ps
`default_nettype none
module wake_sync
    import pwr_mode_pkg::*;
#(
    parameter int W = WAKE_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] s1_r, s2_r, s3_r, out_r, out_nxt;

    // filtered value only follows when the last two stages agree
    always_comb begin
        out_nxt = out_r;
        for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                out_nxt[i] = s3_r[i];
            end
        end
    end

    // first stage is read only by the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            out_r <= '0;
        end else begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            out_r <= out_nxt;
        end
    end

    assign sync_out = out_r;
endmodule
`default_nettype wire
